// [src/cgps_top.sv]
// Channel group power sequencer: APB registers, group sequencers, clock out.
// Assumes analog stages supply power good, stop-threshold compare and ADC codes.
//
// Overview of operation
// - Clock out pin carries pclk/8 or pclk/4
// - Ungrouped channel follows its selected pin level
// - Host override beats pin control always
// - Ramp rate applied on start and stop
// - Vout readback with target-range weight
// - Fet drop readback with selected range weight
// - Status shows per-channel regulation and fault
// - Target writes accepted only in PWM mode
// - Channel in one group or none
// - Group zero follows enable after config load
// - Groups one, two follow pin or host
// - Start-up proceeds by order position
// - Power-good wait holds next start position
// - Start delay 0-255 ms per position
// - Shut-down proceeds by stop order position
// - Stop-threshold wait holds next stop position
// - Stop delay 0-255 ms per position
// - Vcc and temperature readback
// - Auto reboot after config programming done
// - Reduced variant drops channels one and two
// - Start-up timeout flags fault and event
`timescale 1ns/1ps
`include "cgps_params.svh"

module cgps_top
  import cgps_pkg::*;
#(
  parameter int TICK_CYCLES = `CGPS_TICK_CYCLES
) (
  // APB
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Control pins and straps
  input  wire logic                   chip_enable,
  input  wire logic                   cfg_loaded,
  input  wire logic                   variant_no_ext,
  input  wire logic [4:0]             ctl_pin_in,
  // Analog status
  input  wire logic [3:0]             pwm_mode,
  input  wire logic [3:0]             power_good_flag,
  input  wire logic [3:0]             below_stop,
  input  wire cgps_meas_t [3:0]       meas_in,
  input  wire logic [7:0]             vcc_code,
  input  wire logic [7:0]             temp_code,
  // Channel drive
  output logic      [3:0]             ch_run,
  output cgps_ramp_t [3:0]            ch_ramp,
  output logic      [3:0]             ch_ramp_down,
  output cgps_tgt_t [3:0]             ch_target,
  // Clock out, events
  output logic                        clock_out_pin,
  output logic                        clock_out_pin_oe,
  output logic                        supply_fault_event,
  output logic                        reboot_req
);

  cgps_cfg_t  cfg_r [4];
  cgps_ramp_t [3:0] ramp_r;
  cgps_tgt_t  [3:0] tgt_r;
  logic [31:0] ctrl_r;
  logic [31:0] pinsel_r;
  logic [15:0] ovr_r;
  logic [3:0]  fault_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        variant_r;
  logic [2:0]  div_r;
  logic        clk_out_r;
  logic        clk_oe_r;
  logic [14:0] tick_cnt_r;
  logic        tick_r;
  cgps_seq_t   seq_r [3];
  logic [1:0]  pos_r [3];
  logic [7:0]  dly_r [3];
  logic [3:0]  seq_on_r [3];
  logic [3:0]  run_r;
  logic [3:0]  down_r;
  logic [7:0]  tmo_r [4];
  logic        event_r;
  logic        reboot_r;
  logic        wr_en;
  logic        acc;
  logic [4:0]  pin_mux;
  logic [2:0]  grp_dem;
  logic [3:0]  ind_dem;
  logic [3:0]  absent;

  // Pick one control pin by a 3-bit selector
  function automatic logic pin_pick(input logic [4:0] pins, input logic [2:0] sel);
    pin_pick = (sel < 3'h5) ? pins[sel] : 1'b0;
  endfunction

  // Channels of group g at start (dn=0) or stop (dn=1) position p
  function automatic logic [3:0] pos_mask(input int g, input logic [1:0] p, input logic dn);
    pos_mask = 4'h0;
    for (int c = 0; c < 4; c++) begin
      if (cfg_r[c].group == cgps_grp_t'(g + 1) && (dn ? cfg_r[c].stop_order : cfg_r[c].start_order) == p) begin
        pos_mask[c] = 1'b1;
      end
    end
  endfunction

  // Longest programmed delay among channels of a mask
  function automatic logic [7:0] mask_dly(input logic [3:0] m, input logic dn);
    mask_dly = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (m[c] && (dn ? cfg_r[c].stop_delay : cfg_r[c].start_delay) > mask_dly) begin
        mask_dly = dn ? cfg_r[c].stop_delay : cfg_r[c].start_delay;
      end
    end
  endfunction

  assign acc   = psel && penable;
  assign wr_en = acc && pready_r && pwrite;

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (acc && !pready_r) begin
        unique case (paddr)
          `CGPS_OFF_CTRL:   prdata_r <= ctrl_r;
          `CGPS_OFF_PINSEL: prdata_r <= pinsel_r;
          `CGPS_OFF_OVR:    prdata_r <= {16'h0000, ovr_r};
          `CGPS_OFF_STATUS: prdata_r <= {19'h00000, variant_r, fault_r, run_r, power_good_flag};
          `CGPS_OFF_SUPPLY: prdata_r <= {16'h0000, temp_code, vcc_code};
          default: begin
            if (paddr[7:4] == 4'h2) begin
              prdata_r <= {cfg_r[paddr[3:2]]};
            end else if (paddr[7:4] == 4'h3) begin
              prdata_r <= {16'h0000, ramp_r[paddr[3:2]]};
            end else if (paddr[7:4] == 4'h4) begin
              prdata_r <= {18'h00000, tgt_r[paddr[3:2]]};
            end else if (paddr[7:4] == 4'h5) begin
              // Vout weight follows target range, drop weight follows ctrl bit 3
              prdata_r <= {5'h00, ctrl_r[3], tgt_r[paddr[3:2]].range, meas_in[paddr[3:2]]};
            end else begin
              pslverr_r <= 1'b1;
            end
          end
        endcase
        if (paddr[1:0] != 2'h0) begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `CGPS_CTRL_RST;
      pinsel_r <= `CGPS_PINSEL_RST;
      ovr_r    <= 16'h0000;
      for (int c = 0; c < 4; c++) begin
        cfg_r[c]  <= `CGPS_CFG_RST;
        ramp_r[c] <= `CGPS_RAMP_RST;
        tgt_r[c]  <= `CGPS_TGT_RST;
      end
    end else if (wr_en) begin
      if (paddr == `CGPS_OFF_CTRL) begin
        ctrl_r <= {28'h0000000, pwdata[3:0]};
      end
      if (paddr == `CGPS_OFF_PINSEL) begin
        pinsel_r <= {14'h0000, pwdata[17:0]};
      end
      if (paddr == `CGPS_OFF_OVR) begin
        ovr_r <= pwdata[15:0];
      end
      if (paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0) begin
        cfg_r[paddr[3:2]] <= pwdata;
      end
      if (paddr[7:4] == 4'h3 && paddr[1:0] == 2'h0) begin
        ramp_r[paddr[3:2]] <= pwdata[15:0];
      end
      if (paddr[7:4] == 4'h4 && paddr[1:0] == 2'h0 && pwm_mode[paddr[3:2]]) begin
        tgt_r[paddr[3:2]] <= pwdata[13:0];
      end
    end
  end

  // Reduced variant strap registered every cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      variant_r <= 1'b0;
    end else begin
      variant_r <= variant_no_ext;
    end
  end
  assign absent = variant_r ? 4'b0011 : 4'b0000;

  // Divided clock out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r     <= 3'h0;
      clk_out_r <= 1'b0;
      clk_oe_r  <= 1'b0;
    end else begin
      div_r     <= div_r + 3'h1;
      clk_oe_r  <= ctrl_r[0];
      clk_out_r <= ctrl_r[0] && (ctrl_r[1] ? div_r[1] : div_r[2]);
    end
  end

  // Millisecond tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 15'h0000;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 15'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 15'(TICK_CYCLES - 1)) ? 15'h0000 : tick_cnt_r + 15'h0001;
    end
  end

  // Demand per group and per ungrouped channel; override wins
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_mux[i] = pin_pick(ctl_pin_in, pinsel_r[3*i +: 3]);
    end
    grp_dem[0] = ovr_r[8]  ? ovr_r[12] : (chip_enable && cfg_loaded);
    grp_dem[1] = ovr_r[9]  ? ovr_r[13] : pin_mux[4];
    grp_dem[2] = ovr_r[10] ? ovr_r[14] : pinsel_r[15] ? pin_pick(ctl_pin_in, {1'b0, pinsel_r[17:16]}) : 1'b0;
    for (int c = 0; c < 4; c++) begin
      ind_dem[c] = ovr_r[c] ? ovr_r[c + 4] : pin_mux[c];
    end
  end

  // One sequencer per group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < 3; g++) begin
        seq_r[g]    <= SQ_OFF;
        pos_r[g]    <= 2'h0;
        dly_r[g]    <= 8'h00;
        seq_on_r[g] <= 4'h0;
      end
    end else begin
      for (int g = 0; g < 3; g++) begin
        unique case (seq_r[g])
          SQ_OFF: begin
            if (grp_dem[g]) begin
              seq_r[g] <= SQ_UP_DLY;
              pos_r[g] <= 2'h0;
              dly_r[g] <= 8'h00;
            end
          end
          SQ_UP_DLY: begin
            if (!grp_dem[g]) begin
              seq_r[g] <= SQ_DN_DLY;
              pos_r[g] <= 2'h0;
              dly_r[g] <= 8'h00;
            end else if (dly_r[g] >= mask_dly(pos_mask(g, pos_r[g], 1'b0), 1'b0)) begin
              seq_on_r[g] <= seq_on_r[g] | pos_mask(g, pos_r[g], 1'b0);
              seq_r[g]    <= SQ_UP_WAIT;
            end else if (tick_r) begin
              dly_r[g] <= dly_r[g] + 8'h01;
            end
          end
          SQ_UP_WAIT: begin
            if (!grp_dem[g]) begin
              seq_r[g] <= SQ_DN_DLY;
              pos_r[g] <= 2'h0;
              dly_r[g] <= 8'h00;
            end else begin
              logic [3:0] need;
              need = pos_mask(g, pos_r[g], 1'b0);
              for (int c = 0; c < 4; c++) begin
                need[c] = need[c] && cfg_r[c].power_good_wait_option;
              end
              if ((need & ~power_good_flag) == 4'h0) begin
                seq_r[g] <= (pos_r[g] == 2'h3) ? SQ_ON : SQ_UP_DLY;
                pos_r[g] <= pos_r[g] + 2'h1;
                dly_r[g] <= 8'h00;
              end
            end
          end
          SQ_ON: begin
            if (!grp_dem[g]) begin
              seq_r[g] <= SQ_DN_DLY;
              pos_r[g] <= 2'h0;
              dly_r[g] <= 8'h00;
            end
          end
          SQ_DN_DLY: begin
            if (dly_r[g] >= mask_dly(pos_mask(g, pos_r[g], 1'b1), 1'b1)) begin
              seq_on_r[g] <= seq_on_r[g] & ~pos_mask(g, pos_r[g], 1'b1);
              seq_r[g]    <= SQ_DN_WAIT;
            end else if (tick_r) begin
              dly_r[g] <= dly_r[g] + 8'h01;
            end
          end
          SQ_DN_WAIT: begin
            logic [3:0] need;
            need = pos_mask(g, pos_r[g], 1'b1);
            for (int c = 0; c < 4; c++) begin
              need[c] = need[c] && cfg_r[c].wait_stop;
            end
            if ((need & ~below_stop) == 4'h0) begin
              seq_r[g] <= (pos_r[g] == 2'h3) ? SQ_OFF : SQ_DN_DLY;
              pos_r[g] <= pos_r[g] + 2'h1;
              dly_r[g] <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  // Channel drive, ramp direction and timeout fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r   <= 4'h0;
      down_r  <= 4'h0;
      fault_r <= 4'h0;
      event_r <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        tmo_r[c] <= 8'h00;
      end
    end else begin
      logic [3:0] hit;
      hit = 4'h0;
      for (int c = 0; c < 4; c++) begin
        logic on;
        on = (cfg_r[c].group == CGPS_GRP_NONE) ? ind_dem[c] : seq_on_r[cfg_r[c].group - 2'h1][c];
        run_r[c]  <= on && !absent[c] && !fault_r[c];
        down_r[c] <= !on;
        if (!run_r[c] || power_good_flag[c]) begin
          tmo_r[c] <= 8'h00;
        end else if (tick_r && tmo_r[c] != 8'hff) begin
          tmo_r[c] <= tmo_r[c] + 8'h01;
        end
        // A zero timeout never fires, even once the counter saturates
        hit[c] = run_r[c] && !power_good_flag[c] && tick_r && cfg_r[c].start_timeout != 8'h00
                 && (tmo_r[c] + 8'h01 == cfg_r[c].start_timeout);
      end
      // New faults win over a clear in the same cycle
      if (wr_en && paddr == `CGPS_OFF_STATUS) begin
        fault_r <= (fault_r & ~pwdata[11:8]) | hit;
      end else begin
        fault_r <= fault_r | hit;
      end
      event_r <= |hit;
    end
  end

  // Reboot request after programming completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reboot_r <= 1'b0;
    end else begin
      reboot_r <= wr_en && paddr == `CGPS_OFF_CTRL && pwdata[4] && ctrl_r[2];
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign ch_run             = run_r;
  assign ch_ramp            = ramp_r;
  assign ch_ramp_down       = down_r;
  assign ch_target          = tgt_r;
  assign clock_out_pin      = clk_out_r;
  assign clock_out_pin_oe   = clk_oe_r;
  assign supply_fault_event = event_r;
  assign reboot_req         = reboot_r;

endmodule

// [src/cgps_params.svh]
// Offsets, reset values and timing counts of the channel group power sequencer.
// Assumes a 20 MHz pclk and a byte-addressed APB with 32-bit words.
`ifndef CGPS_PARAMS_SVH
`define CGPS_PARAMS_SVH

`define CGPS_OFF_CTRL     8'h00
`define CGPS_OFF_PINSEL   8'h04
`define CGPS_OFF_OVR      8'h08
`define CGPS_OFF_STATUS   8'h0c
`define CGPS_OFF_SUPPLY   8'h10
`define CGPS_OFF_CFG0     8'h20
`define CGPS_OFF_RAMP0    8'h30
`define CGPS_OFF_TGT0     8'h40
`define CGPS_OFF_MEAS0    8'h50

`define CGPS_CTRL_RST     32'h0000_0000
`define CGPS_PINSEL_RST   32'h0000_0000
`define CGPS_CFG_RST      32'h0000_0000
`define CGPS_RAMP_RST     16'h0000
`define CGPS_TGT_RST      14'h0000

`define CGPS_PCLK_PERIOD_NS 50
`define CGPS_TICK_NS        1000000
`define CGPS_TICK_CYCLES    (`CGPS_TICK_NS / `CGPS_PCLK_PERIOD_NS)

// Readback weights: vout 15/30/60 mV, fet drop 1.25/2.5 mV, vcc 200 mV, temp 5 C
// Target step: 2.5/5/10 mV by target range; stop threshold 600 mV (comparator input)
`endif

// [src/cgps_pkg.sv]
// Types shared by the channel group power sequencer.
// Assumes cgps_params.svh for numeric constants.
package cgps_pkg;
  typedef enum logic [1:0] {CGPS_GRP_NONE, CGPS_GRP_0, CGPS_GRP_1, CGPS_GRP_2} cgps_grp_t;

  typedef struct packed {
    logic [7:0] start_timeout;
    logic [7:0] stop_delay;
    logic [7:0] start_delay;
    logic       wait_stop;
    logic       power_good_wait_option;
    logic [1:0] stop_order;
    logic [1:0] start_order;
    cgps_grp_t  group;
  } cgps_cfg_t;

  typedef struct packed {
    logic [7:0] down_rate;
    logic [7:0] up_rate;
  } cgps_ramp_t;

  typedef struct packed {
    logic [1:0]  range;
    logic [11:0] code;
  } cgps_tgt_t;

  typedef struct packed {
    logic [11:0] vout;
    logic [11:0] fet_drop;
  } cgps_meas_t;

  typedef enum {SQ_OFF, SQ_UP_DLY, SQ_UP_WAIT, SQ_ON, SQ_DN_DLY, SQ_DN_WAIT} cgps_seq_t;
endpackage

// [tb/cgps_top_properties.sv]
// Checker for the sequencer top: APB handshake, clock out, events, strap.
// Assumes binding to cgps_top; tracks the control word from APB writes.
`timescale 1ns/1ps
module cgps_top_properties
  import cgps_pkg::*;
(
  // APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Pins and analog status
  input wire logic             variant_no_ext,
  input wire logic [3:0]       pwm_mode,
  input wire logic [3:0]       power_good_flag,
  input wire logic [7:0]       vcc_code,
  input wire logic [7:0]       temp_code,
  // Outputs
  input wire logic [3:0]       ch_run,
  input wire cgps_tgt_t [3:0]  ch_target,
  input wire logic             clock_out_pin,
  input wire logic             clock_out_pin_oe,
  input wire logic             supply_fault_event,
  input wire logic             reboot_req
);
  logic [1:0] ctl_r;
  logic [3:0] quiet_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Divider setting and settle time since its last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r   <= 2'h0;
      quiet_r <= 4'h0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      ctl_r   <= pwdata[1:0];
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  clkout_div4_a: assert property (
    ctl_r == 2'h3 && quiet_r == 4'hf |-> clock_out_pin_oe && clock_out_pin != $past(clock_out_pin, 2))
    else $error("clock out not pclk/4");
  clkout_div8_a: assert property (
    ctl_r == 2'h1 && quiet_r == 4'hf |-> clock_out_pin_oe && clock_out_pin != $past(clock_out_pin, 4)
      && clock_out_pin == $past(clock_out_pin, 8))
    else $error("clock out not pclk/8");
  clkout_off_a: assert property (
    !ctl_r[0] && quiet_r == 4'hf |-> !clock_out_pin_oe)
    else $error("clock out driven while off");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && penable && pready && paddr == 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  supply_read_a: assert property (
    psel && penable && pready && !pwrite && paddr == 8'h10 |-> prdata[15:0] == {temp_code, vcc_code})
    else $error("supply readback wrong");
  target_pwm_a: assert property (
    $changed(ch_target[0]) |-> $past(pwm_mode[0]) && $past(pready) && $past(pwrite))
    else $error("target changed outside pwm write");
  reboot_cause_a: assert property (
    reboot_req |-> $past(pwrite) && $past(pwdata[4]) && $past(paddr) == 8'h00 && !$past(reboot_req))
    else $error("reboot without program done write");
  fault_cause_a: assert property (
    supply_fault_event |-> |($past(ch_run) & ~$past(power_good_flag)) ##1 !supply_fault_event)
    else $error("fault event without pending start");
  variant_off_a: assert property (variant_no_ext [*3] |-> ch_run[1:0] == 2'b00)
    else $error("absent channel running");
endmodule

bind cgps_top cgps_top_properties u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .variant_no_ext, .pwm_mode, .power_good_flag, .vcc_code, .temp_code,
  .ch_run, .ch_target, .clock_out_pin, .clock_out_pin_oe, .supply_fault_event, .reboot_req);

// [tb/cgps_analog_model.sv]
// Analog channel stand-in: power good and stop-threshold flags lag the run enables.
// Assumes pclk runs free; DLY sets how slowly an output ramps either way.
`timescale 1ns/1ps
module cgps_analog_model #(
  parameter int DLY = 15
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] ch_run,
  input  wire logic [3:0] pg_stuck,
  output logic      [3:0] power_good_flag,
  output logic      [3:0] below_stop
);
  int lvl_r [4];

  // Output level climbs while enabled and falls while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= '{default: 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ch_run[i] && lvl_r[i] < DLY) lvl_r[i] <= lvl_r[i] + 1;
        else if (!ch_run[i] && lvl_r[i] > 0) lvl_r[i] <= lvl_r[i] - 1;
      end
    end
  end

  // A stuck channel never reaches regulation
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      power_good_flag[i] = (lvl_r[i] == DLY) && !pg_stuck[i];
      below_stop[i]      = (lvl_r[i] == 0);
    end
  end
endmodule

// [tb/testbench.sv]
// Directed bench for the sequencer top over APB with an analog stand-in.
// Assumes a 1 ms tick shortened to 10 pclk cycles.
`timescale 1ns/1ps
module testbench
  import cgps_pkg::*;
;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic              chip_enable = 0, cfg_loaded = 0, variant_no_ext = 0;
  logic [7:0]        paddr = 8'h00, vcc_code = 8'h3c, temp_code = 8'h0b;
  logic [31:0]       pwdata = 32'h0, prdata, r;
  logic [4:0]        ctl_pin_in = 5'h00;
  logic [3:0]        pwm_mode = 4'h0, pg_stuck = 4'h0, power_good_flag, below_stop, ch_run, ch_ramp_down;
  cgps_meas_t [3:0]  meas_in = {4{24'h123456}};
  cgps_ramp_t [3:0]  ch_ramp;
  cgps_tgt_t [3:0]   ch_target;
  logic              pready, pslverr, clock_out_pin, clock_out_pin_oe, supply_fault_event, reboot_req, e;
  int                n_errors = 0, check_count = 0, n_ev = 0, n_rb = 0, n_clk = 0, c, k;

  always #25 pclk = ~pclk;

  cgps_top #(.TICK_CYCLES(10)) dut (.*);
  cgps_analog_model #(.DLY(15)) u_analog (.*);

  always @(posedge pclk) begin
    n_ev += supply_fault_event;
    n_rb += reboot_req;
  end
  always @(posedge clock_out_pin) n_clk++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; answer taken at the edge where pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      final_report;
    end
    @(posedge pclk);
  endtask

  task wt(input int i, input logic v);
    c = 0;
    while (ch_run[i] !== v && c < 500) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 500) begin
      n_errors++;
      final_report;
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h10, 0);
    chk(r[15:0], 16'h0b3c);
    apb(0, 8'h14, 0);
    chk(e, 1'b1);
    apb(0, 8'h0c, 0);
    chk(r, 32'h0);
    for (int m = 1; m <= 3; m += 2) begin
      apb(1, 8'h00, m);
      repeat (16) @(posedge pclk);
      n_clk = 0;
      repeat (64) @(posedge pclk);
      chk(n_clk, (m + 1) * 4);
    end
    apb(1, 8'h00, 0);
    repeat (4) @(posedge pclk);
    chk(clock_out_pin_oe, 1'b0);
    apb(1, 8'h40, 32'h1abc);
    chk(ch_target[0], 14'h0);
    pwm_mode <= 4'hf;
    apb(1, 8'h40, 32'h1abc);
    chk(ch_target[0], 14'h1abc);
    apb(1, 8'h00, 32'h8);
    apb(0, 8'h50, 0);
    chk(r, 32'h0512_3456);
    // Ungrouped channel follows its pin, host override wins
    apb(1, 8'h04, 32'h1);
    ctl_pin_in[1] <= 1'b1;
    wt(0, 1'b1);
    chk(c < 8, 1'b1);
    apb(1, 8'h08, 32'h1);
    wt(0, 1'b0);
    chk(c < 8, 1'b1);
    apb(1, 8'h08, 32'h0);
    ctl_pin_in[1] <= 1'b0;
    wt(0, 1'b0);
    // Group one: delayed start, power-good wait, stop-threshold wait
    apb(1, 8'h28, 32'h252);
    apb(1, 8'h2c, 32'h86);
    apb(1, 8'h38, 32'h3456);
    chk(ch_ramp[2], 16'h3456);
    apb(1, 8'h04, 32'h3000);
    ctl_pin_in[3] <= 1'b1;
    wt(2, 1'b1);
    chk(c >= 10 && c <= 25, 1'b1);
    chk(ch_run[3], 1'b0);
    wt(3, 1'b1);
    chk(c >= 15, 1'b1);
    // Let channel four reach full level so its stop-threshold wait is real
    repeat (16) @(posedge pclk);
    ctl_pin_in[3] <= 1'b0;
    wt(3, 1'b0);
    chk(ch_ramp_down[3], 1'b1);
    wt(2, 1'b0);
    chk(c >= 15, 1'b1);
    // Group zero on enable after load, then start-up timeout
    pg_stuck <= 4'h2;
    apb(1, 8'h24, 32'h0200_0001);
    chip_enable <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(ch_run[1], 1'b0);
    @(posedge pclk);
    cfg_loaded <= 1'b1;
    wt(1, 1'b1);
    chk(c < 10, 1'b1);
    wt(1, 1'b0);
    chk(c >= 10 && c <= 25, 1'b1);
    chk(n_ev, 1);
    apb(0, 8'h0c, 0);
    chk(r[9], 1'b1);
    chip_enable <= 1'b0;
    apb(1, 8'h0c, 32'h200);
    apb(0, 8'h0c, 0);
    chk(r[9], 1'b0);
    // Reboot only with auto reset already set
    apb(1, 8'h00, 32'h10);
    apb(1, 8'h00, 32'h4);
    apb(1, 8'h00, 32'h14);
    repeat (2) @(posedge pclk);
    chk(n_rb, 1);
    variant_no_ext <= 1'b1;
    apb(1, 8'h08, 32'h11);
    repeat (5) @(posedge pclk);
    chk(ch_run[0], 1'b0);
    apb(0, 8'h0c, 0);
    chk(r[12], 1'b1);
    // Group two from its own pin, then host group override wins
    apb(1, 8'h28, 32'h3);
    apb(1, 8'h04, 32'h38000);
    ctl_pin_in[3] <= 1'b1;
    wt(2, 1'b1);
    chk(c < 8, 1'b1);
    apb(1, 8'h08, 32'h411);
    wt(2, 1'b0);
    chk(c < 8, 1'b1);
    final_report;
  end
endmodule
